// ===== cies_pkg.sv
// constants and types for the instruction execution slice
package cies_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] FILE_MAX = 5'h1F;  // highest file address
  localparam logic [ADDR_W-1:0] DIR_PORT_A = 5'h06;  // first direction register
  localparam logic [ADDR_W-1:0] DIR_PORT_B = 5'h07;  // second direction register
  localparam logic [DATA_W-1:0] WDT_CLEAR = 8'h00;  // watchdog count after sleep
  localparam logic [DATA_W-1:0] DIR_RESET = 8'hFF;  // direction regs reset to input
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam int MSB = 7;  // top bit of a byte
  localparam int HALF_MSB = 3;  // top bit of the low nibble
  localparam logic DEST_ACC = 1'b0;  // destination select: accumulator
  localparam logic DEST_FILE = 1'b1;  // destination select: file register
  // operations this slice executes
  typedef enum logic [2:0] {
    CIES_OP_NONE, CIES_OP_SLEEP, CIES_OP_RLC, CIES_OP_RRC,
    CIES_OP_SUB, CIES_OP_SWAP, CIES_OP_DIR, CIES_OP_XORF
  } cies_op_t;
endpackage : cies_pkg

// ===== cies_exec.sv
// one execution slice of the 8-bit core: sleep, rotates, subtract, swap, direction, xor
module cies_exec (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction issue, same clock domain
  input wire logic instr_valid,
  input wire cies_pkg::cies_op_t instr_op,
  input wire logic xor_lit_valid,
  input wire logic [7:0] instr_literal,
  input wire logic [4:0] instr_file,
  input wire logic instr_dest,
  input wire logic wake_event,
  // file register read port
  input wire logic [7:0] file_rdata,
  // file register write port
  output logic file_we,
  output logic [4:0] file_waddr,
  output logic [7:0] file_wdata,
  // architectural state
  output logic [7:0] acc,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic zero_flag,
  output logic watchdog_expiry_status_bit,
  output logic power_down_flag,
  output logic pin_change_wakeup_flag,
  output logic [7:0] dir_port_a,
  output logic [7:0] dir_port_b,
  // watchdog and sleep control
  output logic watchdog_clear,
  output logic osc_run,
  output logic sleeping
);
  logic go;  // an instruction accepted this cycle
  logic [7:0] res;  // 8-bit result
  logic [8:0] diff;  // subtraction with borrow-out column
  logic [4:0] hdiff;  // low-nibble subtraction
  logic new_c;
  logic upd_c, upd_dc, upd_z, wr_res;

  // zero detect is shared by several operations
  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction : is_zero

  // sleeping core takes no instruction
  assign go = (instr_valid || xor_lit_valid) && !sleeping;

  assign diff = {1'b0, file_rdata} - {1'b0, acc};
  assign hdiff = {1'b0, file_rdata[cies_pkg::HALF_MSB:0]} - {1'b0, acc[cies_pkg::HALF_MSB:0]};

  // result and flag-update selection
  always_comb begin
    res = file_rdata;
    new_c = carry_flag;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    wr_res = 1'b0;
    if (xor_lit_valid) begin
      res = acc ^ instr_literal;
      upd_z = 1'b1;
    end else begin
      case (instr_op)
        cies_pkg::CIES_OP_RLC: begin
          res = {file_rdata[cies_pkg::MSB-1:0], carry_flag};
          new_c = file_rdata[cies_pkg::MSB];
          upd_c = 1'b1;
          wr_res = 1'b1;
        end
        cies_pkg::CIES_OP_RRC: begin
          res = {carry_flag, file_rdata[cies_pkg::MSB:1]};
          new_c = file_rdata[0];
          upd_c = 1'b1;
          wr_res = 1'b1;
        end
        cies_pkg::CIES_OP_SUB: begin
          res = diff[7:0];
          new_c = !diff[8];
          upd_c = 1'b1;
          upd_dc = 1'b1;
          upd_z = 1'b1;
          wr_res = 1'b1;
        end
        cies_pkg::CIES_OP_SWAP: begin
          res = {file_rdata[cies_pkg::HALF_MSB:0],
                 file_rdata[cies_pkg::MSB:cies_pkg::HALF_MSB+1]};
          wr_res = 1'b1;
        end
        cies_pkg::CIES_OP_XORF: begin
          res = acc ^ file_rdata;
          upd_z = 1'b1;
          wr_res = 1'b1;
        end
        default: begin
          res = file_rdata;
        end
      endcase
    end
  end

  // accumulator: literal xor always lands here, others when dest is zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= cies_pkg::ACC_RESET;
    end else if (go && (xor_lit_valid || (wr_res && instr_dest == cies_pkg::DEST_ACC))) begin
      acc <= res;
    end
  end

  // file write port, registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      file_we <= 1'b0;
      file_waddr <= 5'h00;
      file_wdata <= 8'h00;
    end else begin
      file_we <= go && !xor_lit_valid && wr_res && instr_dest == cies_pkg::DEST_FILE;
      file_waddr <= instr_file;
      file_wdata <= res;
    end
  end

  // arithmetic flags; untouched ops leave them as they are
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_flag <= 1'b0;
      half_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
    end else if (go) begin
      if (upd_c) carry_flag <= new_c;
      if (upd_dc) half_carry_flag <= !hdiff[4];
      if (upd_z) zero_flag <= is_zero(res);
    end
  end

  // direction registers, loaded from the accumulator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_port_a <= cies_pkg::DIR_RESET;
      dir_port_b <= cies_pkg::DIR_RESET;
    end else if (go && !xor_lit_valid && instr_op == cies_pkg::CIES_OP_DIR) begin
      if (instr_file == cies_pkg::DIR_PORT_A) dir_port_a <= acc;
      if (instr_file == cies_pkg::DIR_PORT_B) dir_port_b <= acc;
    end
  end

  // sleep entry: status bits, watchdog clear pulse, halt until wake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_expiry_status_bit <= 1'b1;
      power_down_flag <= 1'b1;
      pin_change_wakeup_flag <= 1'b0;  // wake detail lives elsewhere; held here
      watchdog_clear <= 1'b0;
      sleeping <= 1'b0;
      osc_run <= 1'b1;
    end else begin
      watchdog_clear <= 1'b0;
      if (go && !xor_lit_valid && instr_op == cies_pkg::CIES_OP_SLEEP) begin
        watchdog_expiry_status_bit <= 1'b1;
        power_down_flag <= 1'b0;
        watchdog_clear <= 1'b1;
        sleeping <= 1'b1;
        osc_run <= 1'b0;
      end else if (sleeping && wake_event) begin
        sleeping <= 1'b0;
        osc_run <= 1'b1;
      end
    end
  end

  // sleep must pulse the watchdog clear and drop power-down next cycle
  property p_sleep_effects;
    @(posedge clk) disable iff (!rst_n)
      (go && !xor_lit_valid && instr_op == cies_pkg::CIES_OP_SLEEP) |=>
        (watchdog_clear && !power_down_flag && watchdog_expiry_status_bit && sleeping);
  endproperty
  a_sleep_effects: assert property (p_sleep_effects) else $error("sleep effects missing");
  property p_wake_flag_kept;
    @(posedge clk) disable iff (!rst_n)
      (go && instr_op == cies_pkg::CIES_OP_SLEEP) |=> $stable(pin_change_wakeup_flag);
  endproperty
  a_wake_flag_kept: assert property (p_wake_flag_kept) else $error("wake flag changed");
  property p_halt;
    @(posedge clk) disable iff (!rst_n)
      (sleeping && !wake_event) |=> ($stable(acc) && !file_we && sleeping && !osc_run);
  endproperty
  a_halt: assert property (p_halt) else $error("core ran while asleep");
  property p_rlc;
    @(posedge clk) disable iff (!rst_n)
      (go && !xor_lit_valid && instr_op == cies_pkg::CIES_OP_RLC
       && instr_dest == cies_pkg::DEST_ACC) |=>
        (acc == {$past(file_rdata[6:0]), $past(carry_flag)} && carry_flag == $past(file_rdata[7])
         && $stable(zero_flag));
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left wrong");
  property p_rrc;
    @(posedge clk) disable iff (!rst_n)
      (go && !xor_lit_valid && instr_op == cies_pkg::CIES_OP_RRC
       && instr_dest == cies_pkg::DEST_FILE) |=>
        (file_we && file_wdata == {$past(carry_flag), $past(file_rdata[7:1])}
         && carry_flag == $past(file_rdata[0]) && $stable(half_carry_flag));
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right wrong");
  property p_sub;
    @(posedge clk) disable iff (!rst_n)
      (go && !xor_lit_valid && instr_op == cies_pkg::CIES_OP_SUB) |=>
        (carry_flag == ($past(file_rdata) >= $past(acc))
         && half_carry_flag == ($past(file_rdata[3:0]) >= $past(acc[3:0])));
  endproperty
  a_sub: assert property (p_sub) else $error("subtract flags wrong");
  property p_swap;
    @(posedge clk) disable iff (!rst_n)
      (go && !xor_lit_valid && instr_op == cies_pkg::CIES_OP_SWAP && instr_dest == 1'b1) |=>
        (file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && $stable(carry_flag));
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_dir;
    @(posedge clk) disable iff (!rst_n)
      (go && !xor_lit_valid && instr_op == cies_pkg::CIES_OP_DIR
       && instr_file == cies_pkg::DIR_PORT_B) |=>
        (dir_port_b == $past(acc) && $stable(dir_port_a) && $stable(zero_flag));
  endproperty
  a_dir: assert property (p_dir) else $error("direction load wrong");
  property p_xorl;
    @(posedge clk) disable iff (!rst_n)
      (go && xor_lit_valid) |=>
        (acc == ($past(acc) ^ $past(instr_literal)) && zero_flag == (acc == 8'h00));
  endproperty
  a_xorl: assert property (p_xorl) else $error("literal xor wrong");
endmodule : cies_exec

// ===== cies_exec_tb.sv
// self-checking random testbench for the instruction execution slice
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, instr_valid, xor_lit_valid, instr_dest, wake_event, file_we;
  cies_pkg::cies_op_t instr_op;
  logic [7:0] instr_literal, file_rdata, acc, file_wdata, dir_port_a, dir_port_b;
  logic [4:0] instr_file, file_waddr;
  logic carry_flag, half_carry_flag, zero_flag, watchdog_expiry_status_bit;
  logic power_down_flag, pin_change_wakeup_flag, watchdog_clear, osc_run, sleeping;
  logic [7:0] mem [0:31];  // bench-owned file registers
  logic [7:0] m_acc, m_da, m_db, res, rd, m_wd;  // expected state
  logic m_c, m_dc, m_z, m_to, m_pd, m_sl, m_wc, m_we, wr;
  logic [4:0] m_wa;
  logic [31:0] r;
  int err_count, n_tests, seed;
  int cyc = 0;
  cies_exec cies_exec_inst (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_op(instr_op), .xor_lit_valid(xor_lit_valid), .instr_literal(instr_literal),
    .instr_file(instr_file), .instr_dest(instr_dest), .wake_event(wake_event),
    .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .acc(acc), .carry_flag(carry_flag),
    .half_carry_flag(half_carry_flag), .zero_flag(zero_flag),
    .watchdog_expiry_status_bit(watchdog_expiry_status_bit),
    .power_down_flag(power_down_flag), .pin_change_wakeup_flag(pin_change_wakeup_flag),
    .dir_port_a(dir_port_a), .dir_port_b(dir_port_b), .watchdog_clear(watchdog_clear),
    .osc_run(osc_run), .sleeping(sleeping));
  // combinational read port, as the core expects
  assign file_rdata = mem[instr_file];
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard: the run needs about 3000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_count++;
      results();
    end
  end
  // file minus accumulator, returns {carry, half carry, zero, result}
  function automatic logic [10:0] f_sub(input logic [7:0] f, input logic [7:0] w);
    logic [8:0] d;
    logic [4:0] h;
    d = {1'b0, f} - {1'b0, w};
    h = {1'b0, f[3:0]} - {1'b0, w[3:0]};
    return {~d[8], ~h[4], d[7:0] == 8'h00, d[7:0]};
  endfunction : f_sub
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // predict the effect of what the core samples at this edge
  task automatic model();
    m_wc = 1'b0;
    m_we = 1'b0;
    wr = 1'b0;
    rd = file_rdata;
    if (m_sl) begin
      if (wake_event) m_sl = 1'b0;  // instructions while asleep are dropped
    end else if (xor_lit_valid) begin
      m_acc = m_acc ^ instr_literal;
      m_z = (m_acc == 8'h00);
    end else if (instr_valid) begin
      case (instr_op)
        cies_pkg::CIES_OP_SLEEP: {m_wc, m_to, m_pd, m_sl} = 4'hD;
        cies_pkg::CIES_OP_RLC: {m_c, res, wr} = {rd, m_c, 1'b1};
        cies_pkg::CIES_OP_RRC: {res, m_c, wr} = {m_c, rd, 1'b1};
        cies_pkg::CIES_OP_SUB: {m_c, m_dc, m_z, res, wr} = {f_sub(rd, m_acc), 1'b1};
        cies_pkg::CIES_OP_SWAP: {res, wr} = {rd[3:0], rd[7:4], 1'b1};
        cies_pkg::CIES_OP_DIR: begin
          if (instr_file == cies_pkg::DIR_PORT_A) m_da = m_acc;
          if (instr_file == cies_pkg::DIR_PORT_B) m_db = m_acc;
        end
        cies_pkg::CIES_OP_XORF: {res, m_z, wr} = {rd ^ m_acc, (rd ^ m_acc) == 8'h00, 1'b1};
        default: ;
      endcase
      if (wr && instr_dest) begin
        {m_we, m_wa, m_wd} = {1'b1, instr_file, res};
        mem[instr_file] <= res;
      end else if (wr) m_acc = res;
    end
  endtask : model
  task automatic check_all();
    check("acc", {8'h00, acc}, {8'h00, m_acc});
    check("flags", {13'h0, carry_flag, half_carry_flag, zero_flag}, {13'h0, m_c, m_dc, m_z});
    check("power", {10'h0, watchdog_expiry_status_bit, power_down_flag, pin_change_wakeup_flag,
      watchdog_clear, sleeping, osc_run}, {10'h0, m_to, m_pd, 1'b0, m_wc, m_sl, ~m_sl});
    check("dir", {dir_port_a, dir_port_b}, {m_da, m_db});
    check("file_we", {15'h0, file_we}, {15'h0, m_we});
    if (m_we) check("file_w", {3'h0, file_waddr, file_wdata}, {3'h0, m_wa, m_wd});
  endtask : check_all
  // one instruction slot: model the edge, drive the next request, then compare
  task automatic issue(input logic [7:0] v, input logic [7:0] lit, input logic [4:0] f);
    @(posedge clk);
    model();
    instr_valid <= v[0];
    instr_op <= cies_pkg::cies_op_t'(v[3:1]);
    xor_lit_valid <= v[4];
    instr_dest <= v[5];
    wake_event <= v[6];
    instr_literal <= lit;
    instr_file <= f;
    #1 check_all();
  endtask : issue
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    seed = 14609;
    {rst_n, instr_valid, xor_lit_valid, instr_dest, wake_event} = 5'h00;
    instr_op = cies_pkg::CIES_OP_NONE;  // enum set on its own, not through a packed concat
    {instr_literal, instr_file} = 13'h0000;
    for (int i = 0; i < 32; i++) mem[i] = 8'($random(seed));
    mem[3] = 8'h10;
    // reset image: flags clear, expiry and power-down set, awake, directions all input
    {m_acc, m_c, m_dc, m_z, m_to, m_pd, m_sl, m_da, m_db} = {8'h00, 6'h06, 16'hFFFF};
    {m_wc, m_we} = 2'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1 check_all();
    // corners: subtract walk, read-after-write, borrow, zero literal, sleep refusal
    issue(8'h10, 8'h05, 5'h00);
    issue(8'h29, 8'h00, 5'h03);
    issue(8'h09, 8'h00, 5'h03);
    issue(8'h09, 8'h00, 5'h04);
    issue(8'h10, 8'h00, 5'h00);
    issue(8'h10, m_acc, 5'h00);
    issue(8'h0D, 8'h00, 5'h07);
    issue(8'h03, 8'h00, 5'h00);
    issue(8'h2B, 8'hAA, 5'h03);
    issue(8'h40, 8'h00, 5'h00);
    repeat (3000) begin
      r = $random(seed);
      issue({1'b0, r[27:25] == 3'h0, r[24], r[7:5] == 3'h0, r[4:2], r[0] | r[1]},
        r[8] ? m_acc : r[23:16], (r[4:2] == 3'h6 && r[9]) ? {4'h3, r[10]} : r[15:11]);
    end
    results();
  end
endmodule : testbench
